//--- hw/cmp_ctrl_pkg.sv
// Constants for the comparator control block: offsets, fields, resets.
// Assumes an 8-bit special-function-register bus on the core clock.
//
// Behaviour
// - The comparator is powered and runs only while the enable bit 7 of the control register is 1.
// - Control bit 6 is a read-only copy of the comparator result, 1 when the positive input is higher.
// - A low-to-high step of the comparator output sets the rise flag in control bit 5.
// - A high-to-low step of the comparator output sets the fall flag in control bit 4.
// - An edge flag stays set until software writes 0 to it, and software clears it after service.
// - Both rise and fall events can request an interrupt, gated by controls kept elsewhere.
// - Control bits 3..2 pick the positive hysteresis: off, 5 mV, 10 mV or 20 mV.
// - Control bits 1..0 pick the negative hysteresis: off, 5 mV, 10 mV or 20 mV.
// - The two-bit negative select of the input register routes pin P0.1, P0.3, P0.5 or P0.7.
// - Input register bits 1..0 route pin P0.0, P0.2, P0.4 or P0.6 to the positive input.
// - The two-bit mode field sets speed against power, 0 fastest, 3 lowest power, reset to mode 2.
// - Unused register bits read as zero and ignore writes.
// - A disabled comparator drives any output routed to a pin low.
// - There is a clocked latched output and a raw output that needs no clock at all.
// - The comparator output is offered to the reset logic as a reset source.

package cmp_ctrl_pkg;

    // Register addresses on the special-function-register bus
    localparam logic [7:0] CONTROL_ADDR    = 8'hf8;
    localparam logic [7:0] INPUT_SEL_ADDR  = 8'h9f;
    localparam logic [7:0] SPEED_SEL_ADDR  = 8'h9d;

    // Reset values
    localparam logic [7:0] CONTROL_RST     = 8'h00;
    localparam logic [7:0] INPUT_SEL_RST   = 8'h00;
    localparam logic [7:0] SPEED_SEL_RST   = 8'h02;

    // Control register fields
    localparam int ENABLE_BIT      = 7;
    localparam int RESULT_BIT      = 6;
    localparam int RISE_BIT        = 5;
    localparam int FALL_BIT        = 4;
    localparam int POS_HYST_LSB    = 2;
    localparam int NEG_HYST_LSB    = 0;

    // Input select fields
    localparam int NEG_INPUT_LSB   = 4;
    localparam int POS_INPUT_LSB   = 0;

    // Speed/power field
    localparam int MODE_LSB        = 0;

    // Number of sticky edge flags and their slots
    localparam int FLAG_COUNT      = 2;
    localparam int FLAG_RISE_IDX   = 1;
    localparam int FLAG_FALL_IDX   = 0;

    // Read masks: unused bits read zero and are not stored
    localparam logic [7:0] INPUT_SEL_MASK  = 8'h33;
    localparam logic [7:0] SPEED_SEL_MASK  = 8'h03;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

endpackage

//--- hw/cmp_sync_if.sv
// Carrier for the synchronised comparator level and its edge pulses.
// Assumes both ends sit on the same core clock.

`timescale 1ns/100ps

interface cmp_sync_if;
    logic level;
    logic rise;
    logic fall;

    // Producer side: the synchroniser
    modport src
    (
        output level,
        output rise,
        output fall
    );

    // Consumer side: the register block
    modport dst
    (
        input  level,
        input  rise,
        input  fall
    );
endinterface

//--- hw/cmp_level_sync.sv
// Two-stage synchroniser with edge detection for the comparator result.
// Assumes the input may change at any time relative to clk.

`timescale 1ns/100ps

module cmp_level_sync
(
    input  wire logic  clk,
    input  wire logic  rstn,
    input  wire logic  async_in,
    cmp_sync_if.src    sync
);

    logic sync_ff1_r;
    logic sync_ff2_r;
    logic level_prev_r;

    // Two synchroniser flip-flops and an edge-history flip-flop; the first feeds only the second
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync_ff1_r   <= 1'b0;
            sync_ff2_r   <= 1'b0;
            level_prev_r <= 1'b0;
        end
        else
        begin
            sync_ff1_r   <= async_in;
            sync_ff2_r   <= sync_ff1_r;
            level_prev_r <= sync_ff2_r;
        end
    end

    // Edge pulses from the settled level
    assign sync.level = sync_ff2_r;
    assign sync.rise  = sync_ff2_r & ~level_prev_r;
    assign sync.fall  = ~sync_ff2_r & level_prev_r;

endmodule

//--- hw/cmp_ctrl.sv
// Control and status registers around the on-chip voltage comparator.
// Assumes a single-cycle special-function-register bus on clk, and an
// analog comparator core whose result arrives unsynchronised.

`timescale 1ns/100ps

module cmp_ctrl
(
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr_en,
    input  wire logic        sfr_rd_en,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // Analog core
    input  wire logic        cmp_analog_in,
    output logic             cmp_power_en,
    output logic      [1:0]  cmp_pos_hyst_sel,
    output logic      [1:0]  cmp_neg_hyst_sel,
    output logic      [1:0]  cmp_pos_input_sel,
    output logic      [1:0]  cmp_neg_input_sel,
    output logic      [1:0]  cmp_response_mode,
    // Digital outputs
    output logic             cmp_latched_out,
    output logic             cmp_raw_out,
    output logic             cmp_reset_src,
    output logic             cmp_rise_irq,
    output logic             cmp_fall_irq
);

    // Address match, used by both the read and write decode
    function automatic logic addr_hit
    (
        input logic [7:0] addr,
        input logic [7:0] target
    );
        addr_hit = (addr == target);
    endfunction

    // Stored register state
    logic                                   enable_r;
    logic [1:0]                             pos_hyst_r;
    logic [1:0]                             neg_hyst_r;
    logic [7:0]                             input_sel_r;
    logic [7:0]                             speed_sel_r;
    logic [cmp_ctrl_pkg::FLAG_COUNT-1:0]    flag_r;
    logic [cmp_ctrl_pkg::FLAG_COUNT-1:0]    flag_nxt;
    logic [7:0]                             rdata_r;
    logic [7:0]                             rdata_nxt;

    // Synchronised comparator view
    cmp_sync_if sync_bus ();

    // Decode strobes
    wire logic control_hit;
    wire logic input_sel_hit;
    wire logic speed_sel_hit;
    wire logic control_wr;
    wire logic input_sel_wr;
    wire logic speed_sel_wr;

    // Edge events and their write values per flag slot
    wire logic [cmp_ctrl_pkg::FLAG_COUNT-1:0] flag_set;
    wire logic [cmp_ctrl_pkg::FLAG_COUNT-1:0] flag_wval;

    // Gated result seen by software and pins
    wire logic result_gated;
    wire logic [7:0] control_view;
    wire logic [7:0] input_sel_view;
    wire logic [7:0] speed_sel_view;

    // Reset value of the control fields, split for the flops
    localparam logic [7:0] CRST = cmp_ctrl_pkg::CONTROL_RST;

    // Synchroniser on the raw comparator result
    cmp_level_sync u_sync
    (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (cmp_analog_in),
        .sync     (sync_bus)
    );

    // Address decode
    assign control_hit   = addr_hit(sfr_addr, cmp_ctrl_pkg::CONTROL_ADDR);
    assign input_sel_hit = addr_hit(sfr_addr, cmp_ctrl_pkg::INPUT_SEL_ADDR);
    assign speed_sel_hit = addr_hit(sfr_addr, cmp_ctrl_pkg::SPEED_SEL_ADDR);
    assign control_wr    = sfr_wr_en & control_hit;
    assign input_sel_wr  = sfr_wr_en & input_sel_hit;
    assign speed_sel_wr  = sfr_wr_en & speed_sel_hit;

    // Result is low whenever the comparator is off
    assign result_gated = enable_r & sync_bus.level;

    // Edges count only while enabled
    assign flag_set[cmp_ctrl_pkg::FLAG_RISE_IDX] =
        enable_r & sync_bus.rise;
    assign flag_set[cmp_ctrl_pkg::FLAG_FALL_IDX] =
        enable_r & sync_bus.fall;
    assign flag_wval[cmp_ctrl_pkg::FLAG_RISE_IDX] =
        sfr_wdata[cmp_ctrl_pkg::RISE_BIT];
    assign flag_wval[cmp_ctrl_pkg::FLAG_FALL_IDX] =
        sfr_wdata[cmp_ctrl_pkg::FALL_BIT];

    // Sticky flags: a hardware set wins over a software clear
    genvar gi;
    generate
        for (gi = 0; gi < cmp_ctrl_pkg::FLAG_COUNT; gi++)
        begin : g_flag
            assign flag_nxt[gi] = flag_set[gi] |
                (control_wr ? flag_wval[gi] : flag_r[gi]);

            always_ff @(posedge clk)
            begin
                if (!rstn)
                    flag_r[gi] <= 1'b0;
                else
                    flag_r[gi] <= flag_nxt[gi];
            end
        end
    endgenerate

    // Control register: enable and hysteresis trims
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            enable_r   <= CRST[cmp_ctrl_pkg::ENABLE_BIT];
            pos_hyst_r <= CRST[cmp_ctrl_pkg::POS_HYST_LSB +: 2];
            neg_hyst_r <= CRST[cmp_ctrl_pkg::NEG_HYST_LSB +: 2];
        end
        else if (control_wr)
        begin
            enable_r   <= sfr_wdata[cmp_ctrl_pkg::ENABLE_BIT];
            pos_hyst_r <= sfr_wdata[cmp_ctrl_pkg::POS_HYST_LSB +: 2];
            neg_hyst_r <= sfr_wdata[cmp_ctrl_pkg::NEG_HYST_LSB +: 2];
        end
    end

    // Input select register; unused bits are never stored
    always_ff @(posedge clk)
    begin
        if (!rstn)
            input_sel_r <= cmp_ctrl_pkg::INPUT_SEL_RST;
        else if (input_sel_wr)
            input_sel_r <= sfr_wdata & cmp_ctrl_pkg::INPUT_SEL_MASK;
    end

    // Speed/power register, reset to mode 2
    always_ff @(posedge clk)
    begin
        if (!rstn)
            speed_sel_r <= cmp_ctrl_pkg::SPEED_SEL_RST;
        else if (speed_sel_wr)
            speed_sel_r <= sfr_wdata & cmp_ctrl_pkg::SPEED_SEL_MASK;
    end

    // Read views; the result bit is read-only
    assign control_view = {
        enable_r,
        result_gated,
        flag_r[cmp_ctrl_pkg::FLAG_RISE_IDX],
        flag_r[cmp_ctrl_pkg::FLAG_FALL_IDX],
        pos_hyst_r,
        neg_hyst_r
    };
    assign input_sel_view = input_sel_r & cmp_ctrl_pkg::INPUT_SEL_MASK;
    assign speed_sel_view = speed_sel_r & cmp_ctrl_pkg::SPEED_SEL_MASK;

    // Read mux; unmapped addresses return zero
    assign rdata_nxt =
        control_hit   ? control_view   :
        input_sel_hit ? input_sel_view :
        speed_sel_hit ? speed_sel_view :
                        cmp_ctrl_pkg::UNMAPPED_READ;

    // Read data registered on a read strobe, held otherwise
    always_ff @(posedge clk)
    begin
        if (!rstn)
            rdata_r <= 8'h00;
        else if (sfr_rd_en)
            rdata_r <= rdata_nxt;
    end

    assign sfr_rdata = rdata_r;

    // Analog core controls
    assign cmp_power_en      = enable_r;
    assign cmp_pos_hyst_sel  = pos_hyst_r;
    assign cmp_neg_hyst_sel  = neg_hyst_r;
    assign cmp_neg_input_sel =
        input_sel_r[cmp_ctrl_pkg::NEG_INPUT_LSB +: 2];
    assign cmp_pos_input_sel =
        input_sel_r[cmp_ctrl_pkg::POS_INPUT_LSB +: 2];
    assign cmp_response_mode =
        speed_sel_r[cmp_ctrl_pkg::MODE_LSB +: 2];

    // Pin outputs: latched from the synchroniser, raw with no clock path
    assign cmp_latched_out = result_gated;
    assign cmp_raw_out     = enable_r & cmp_analog_in;
    assign cmp_reset_src   = enable_r & cmp_analog_in;

    // Interrupt requests follow the sticky flags
    assign cmp_rise_irq = flag_r[cmp_ctrl_pkg::FLAG_RISE_IDX];
    assign cmp_fall_irq = flag_r[cmp_ctrl_pkg::FLAG_FALL_IDX];

endmodule

//--- sim/cmp_ctrl_properties.sv
// Concurrent checks on the comparator control block ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module cmp_ctrl_properties
(
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr_en,
    input wire logic [7:0] sfr_wdata,
    input wire logic       cmp_analog_in,
    input wire logic       cmp_power_en,
    input wire logic [1:0] cmp_pos_hyst_sel,
    input wire logic [1:0] cmp_neg_hyst_sel,
    input wire logic [1:0] cmp_pos_input_sel,
    input wire logic [1:0] cmp_neg_input_sel,
    input wire logic [1:0] cmp_response_mode,
    input wire logic       cmp_latched_out,
    input wire logic       cmp_raw_out,
    input wire logic       cmp_reset_src,
    input wire logic       cmp_rise_irq,
    input wire logic       cmp_fall_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Write strobes per register
    wire wr_ctl = sfr_wr_en && sfr_addr == cmp_ctrl_pkg::CONTROL_ADDR;
    wire wr_in  = sfr_wr_en && sfr_addr == cmp_ctrl_pkg::INPUT_SEL_ADDR;
    wire wr_md  = sfr_wr_en && sfr_addr == cmp_ctrl_pkg::SPEED_SEL_ADDR;
    property p_pwr; wr_ctl |=> cmp_power_en == $past(sfr_wdata[7]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("enable");
    property p_hyst; wr_ctl |=>
        {cmp_pos_hyst_sel, cmp_neg_hyst_sel} == $past(sfr_wdata[3:0]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hyst");
    property p_insel; wr_in |=> {cmp_neg_input_sel, cmp_pos_input_sel}
        == {$past(sfr_wdata[5:4]), $past(sfr_wdata[1:0])};
    endproperty
    a_insel: assert property (p_insel) else $error("mux");
    property p_mode; wr_md |=> cmp_response_mode == $past(sfr_wdata[1:0]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_off; !cmp_power_en |-> !cmp_latched_out && !cmp_raw_out;
    endproperty
    a_off: assert property (p_off) else $error("disabled out");
    property p_raw; cmp_raw_out == (cmp_power_en && cmp_analog_in)
        && cmp_reset_src == cmp_raw_out;
    endproperty
    a_raw: assert property (p_raw) else $error("raw");
    property p_lat; (cmp_power_en && cmp_analog_in) [*3] |-> cmp_latched_out;
    endproperty
    a_lat: assert property (p_lat) else $error("latched");
    property p_rise; cmp_power_en && $past(cmp_power_en)
        && $rose(cmp_latched_out) |=> cmp_rise_irq;
    endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_fall; cmp_power_en && $past(cmp_power_en)
        && $fell(cmp_latched_out) |=> cmp_fall_irq;
    endproperty
    a_fall: assert property (p_fall) else $error("fall");
    property p_hold; cmp_rise_irq && !wr_ctl |=> cmp_rise_irq; endproperty
    a_hold: assert property (p_hold) else $error("sticky");
    property p_hold_fall; cmp_fall_irq && !wr_ctl |=> cmp_fall_irq;
    endproperty
    a_hold_fall: assert property (p_hold_fall) else $error("sticky");
    c_rise: cover property (cmp_rise_irq);
    c_fall: cover property (cmp_fall_irq);
    c_off: cover property ($fell(cmp_power_en));
endmodule

//--- sim/cmp_analog_model.sv
// Analog comparator core with port pin voltages in millivolts.
// Assumes the bench sets pin levels; output is not gated by power.
`timescale 1ns/100ps
module cmp_analog_model
(
    input var int          pin_mv [8],
    input wire logic [1:0] pos_sel,
    input wire logic [1:0] neg_sel,
    output logic      cmp_out
);
    // Even pins feed the positive side, odd pins the negative side
    always_comb
        cmp_out = pin_mv[{pos_sel, 1'b0}] > pin_mv[{neg_sel, 1'b1}];
endmodule

//--- sim/test_cmp_ctrl.sv
// Self-checking bench for the comparator control block.
// Assumes the analog model turns pin voltages into the raw result.
`timescale 1ns/100ps
module test_cmp_ctrl;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr_en = 1'b0;
    logic       sfr_rd_en = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic       cmp_analog_in, cmp_power_en, latched, raw, rst_src;
    logic       rise_irq, fall_irq;
    logic [1:0] pos_hyst, neg_hyst, pos_sel, neg_sel, mode;
    int         pin_mv [8] = '{default: 0};
    int         err_total = 0;
    int         checks_done = 0;
    int         cycles = 0;
    logic [7:0] ra [3] = '{cmp_ctrl_pkg::CONTROL_ADDR,
        cmp_ctrl_pkg::INPUT_SEL_ADDR, cmp_ctrl_pkg::SPEED_SEL_ADDR};

    cmp_ctrl dut_u (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .cmp_analog_in(cmp_analog_in),
        .cmp_power_en(cmp_power_en), .cmp_pos_hyst_sel(pos_hyst),
        .cmp_neg_hyst_sel(neg_hyst), .cmp_pos_input_sel(pos_sel),
        .cmp_neg_input_sel(neg_sel), .cmp_response_mode(mode),
        .cmp_latched_out(latched), .cmp_raw_out(raw),
        .cmp_reset_src(rst_src), .cmp_rise_irq(rise_irq),
        .cmp_fall_irq(fall_irq));
    cmp_analog_model pin_u (.pin_mv(pin_mv), .pos_sel(pos_sel),
        .neg_sel(neg_sel), .cmp_out(cmp_analog_in));

    // Clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            close_out();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobes, driven just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(posedge clk) #1;
        sfr_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        @(posedge clk) #1;
        sfr_rd_en = 1'b0;
        check(sfr_rdata, exp);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        rd(ra[0], 8'h00);
        rd(ra[2], 8'h02);
        check(mode, 8'h02);
        wr(ra[1], 8'hff);
        rd(ra[1], 8'h33);
        wr(ra[2], 8'hfc);
        rd(ra[2], 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(ra[0], 8'h40 | 8'(k * 5));
            wr(ra[1], 8'(k * 17));
            wr(ra[2], 8'(k));
            check(pos_hyst, 8'(k));
            check(neg_hyst, 8'(k));
            check(pos_sel, 8'(k));
            check(neg_sel, 8'(k));
            check(mode, 8'(k));
            rd(ra[0], 8'(k * 5));
        end
        wr(ra[1], 8'h00);
        pin_mv[1] = 100;
        wr(ra[0], 8'h80);
        check(cmp_power_en, 8'h01);
        pin_mv[0] = 200;
        #1 check(raw, 8'h01);
        check(rst_src, 8'h01);
        repeat (4) @(posedge clk);
        rd(ra[0], 8'he0);
        check(rise_irq, 8'h01);
        pin_mv[0] = 0;
        repeat (4) @(posedge clk);
        rd(ra[0], 8'hb0);
        check(fall_irq, 8'h01);
        pin_mv[0] = 200;
        repeat (4) @(posedge clk);
        rd(ra[0], 8'hf0);
        wr(ra[0], 8'hc0);
        rd(ra[0], 8'hc0);
        // Fall event lands on the edge of a clearing write: set wins
        pin_mv[0] = 0;
        @(posedge clk);
        wr(ra[0], 8'h80);
        rd(ra[0], 8'h90);
        check(fall_irq, 8'h01);
        // Writing 1 to a flag sets it, writing 0 clears it
        wr(ra[0], 8'ha0);
        rd(ra[0], 8'ha0);
        check(rise_irq, 8'h01);
        check(fall_irq, 8'h00);
        // Settle a high result, then disable
        pin_mv[0] = 200;
        repeat (4) @(posedge clk);
        check(latched, 8'h01);
        wr(ra[0], 8'h00);
        @(posedge clk) #1;
        check(latched, 8'h00);
        check(raw, 8'h00);
        check(rst_src, 8'h00);
        pin_mv[0] = 0;
        repeat (4) @(posedge clk);
        rd(ra[0], 8'h00);
        // Mid-run reset brings mode 3 back to mode 2
        @(posedge clk) #1;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        #1 rstn = 1'b1;
        check(mode, 8'h02);
        rd(ra[2], 8'h02);
        close_out();
    end
endmodule

bind cmp_ctrl cmp_ctrl_properties chk_u (.clk(clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
    .cmp_analog_in(cmp_analog_in), .cmp_power_en(cmp_power_en),
    .cmp_pos_hyst_sel(cmp_pos_hyst_sel), .cmp_neg_hyst_sel(cmp_neg_hyst_sel),
    .cmp_pos_input_sel(cmp_pos_input_sel),
    .cmp_neg_input_sel(cmp_neg_input_sel),
    .cmp_response_mode(cmp_response_mode), .cmp_latched_out(cmp_latched_out),
    .cmp_raw_out(cmp_raw_out), .cmp_reset_src(cmp_reset_src),
    .cmp_rise_irq(cmp_rise_irq), .cmp_fall_irq(cmp_fall_irq));
